// >>> verilog/sst_pkg.sv
// constants, register map and field positions of the sensor status and tick registers
// Function
// - free-running 8-bit tick counter wraps, 25.6 ms
// - counter advances every 100 us via /1000 prescaler
// - tick register read-only, resets zero, mode-gated reads
// - status registers 01..04 read-only, mode-gated reads
// - dsp fault flag ORs five dsp conditions
// - link fault summary set by link register
// - memory/temperature summary ORs five status bits
// - supply summary ORs seven supply fault bits
// - shared recovery timer reloads on error, counts down
// - dsi3 policy: silence, then error code once
// - dsi3 policy: read or report clears at zero
// - psi5 or policy set: silence, auto clear
// - reset flag set by reset, cleared when reported
// - initialising set by reset or config change
// - supply register cleared after two clean reads
// - buffer undervoltage bit follows monitor, timer clears
// - bus input undervoltage bit follows monitor
// - otp write-active bit live while writing
// - memory/temperature bits cleared when reported
package sst_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int OSC_HZ = 10_000_000;
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    localparam int PRESCALE_DIV = 1000;
    localparam int TICK_TIME_NS = 100_000;
    localparam int TICK_CYCLES = TICK_TIME_NS / (1_000_000_000 / CLK_HZ);
    localparam int SUPPLY_RECOVERY_TIME_US = 1000;
    localparam int SUPPLY_RECOVERY_TICKS = SUPPLY_RECOVERY_TIME_US * 1000 / TICK_TIME_NS;

    localparam logic [7:0] ADDR_TICK_COUNTER = 8'h00;
    localparam logic [7:0] ADDR_TOP_DEVICE_STATUS = 8'h01;
    localparam logic [7:0] ADDR_SUPPLY_FAULT_STATUS = 8'h02;
    localparam logic [7:0] ADDR_MEMORY_TEMP_STATUS = 8'h03;
    localparam logic [7:0] ADDR_LINK_FAULT_STATUS = 8'h04;
    localparam logic [7:0] TICK_COUNTER_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // top status field positions
    localparam int TOP_DSP_BIT = 7;
    localparam int TOP_LINK_BIT = 5;
    localparam int TOP_MEMTEMP_BIT = 4;
    localparam int TOP_SUPPLY_BIT = 3;
    localparam int TOP_TEST_BIT = 2;
    localparam int TOP_RESET_BIT = 1;
    localparam int TOP_INIT_BIT = 0;
    // supply fault status: monitor vector order is the register bit order
    localparam int SUP_BUF_LOW_BIT = 7;
    localparam int SUP_BUS_LOW_BIT = 6;
    localparam logic [7:0] SUPPLY_USED_MASK = 8'hEF;
    // memory/temperature status
    localparam int MT_WRITE_ACTIVE_BIT = 4;
    localparam logic [7:0] MEMTEMP_USED_MASK = 8'hF4;
    localparam int LINK_OSC_BIT = 0;

    localparam logic [2:0] TYPE_DSI3_A = 3'h0;
    localparam logic [2:0] TYPE_DSI3_B = 3'h3;
    localparam logic [2:0] TYPE_PSI5_A = 3'h1;
    localparam logic [2:0] TYPE_PSI5_B = 3'h5;
endpackage : sst_pkg

// >>> verilog/sst_status_regs.sv
// tick counter, status summaries, supply recovery timer and read port of the sensor
module sst_status_regs
    import sst_pkg::*;
#(
    parameter int TIMER_W = 8,
    parameter int RECOVERY_TICKS = SUPPLY_RECOVERY_TICKS,
    parameter int TIMER_RATE_TICKS = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // mode selection
    input wire logic [2:0] interface_type_select,
    input wire logic psi5_diag_mode,
    input wire logic power_fault_clear_policy,
    // register read port
    input wire logic rd_strobe,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    output logic rd_ack,
    output logic rd_refused,
    // transmission slots from the link
    input wire logic tx_slot,
    input wire logic tx_status_included,
    output logic tx_permit,
    output logic tx_send_error_code,
    // dsp conditions
    input wire logic pressure_over_range,
    input wire logic pressure_under_range,
    input wire logic selftest_incomplete,
    input wire logic common_mode_fault,
    input wire logic selftest_fault,
    // supply monitors, register bit order, bit 4 unused
    input wire logic [7:0] supply_monitor,
    // memory, temperature and link monitors
    input wire logic factory_otp_fault,
    input wire logic user_otp_fault,
    input wire logic user_rw_fault,
    input wire logic user_otp_writing,
    input wire logic temperature_fault,
    input wire logic oscillator_training_fault,
    // device state
    input wire logic factory_test_active,
    input wire logic [3:0] channel_config_upper,
    input wire logic sensor_data_valid,
    // status view
    output logic [TIMER_W-1:0] recovery_timer,
    output logic [7:0] tick_counter
);
    localparam logic [TIMER_W-1:0] TIMER_RELOAD = TIMER_W'(RECOVERY_TICKS);
    localparam logic [TIMER_W-1:0] TIMER_ZERO = '0;
    localparam logic [9:0] PRESCALE_TERM = 10'(PRESCALE_DIV - 1);
    localparam logic [1:0] OSC_TERM = 2'(OSC_DIV - 1);
    localparam logic [7:0] RATE_TERM = 8'(TIMER_RATE_TICKS - 1);

    logic [1:0] osc_div;
    logic osc_en;
    logic [9:0] prescaler;
    logic tick_en;
    logic [7:0] rate_div;
    logic timer_step;
    logic [7:0] supply_fault_status;
    logic [7:0] memory_temp_status;
    logic [7:0] link_fault_status;
    logic [7:0] top_device_status;
    logic [7:0] supply_live;
    logic [7:0] memtemp_live;
    logic supply_live_any;
    logic dsp_fault;
    logic link_fault_summary;
    logic memory_temperature_summary;
    logic supply_summary;
    logic reset_occurred;
    logic initialising;
    logic [3:0] cfg_prev;
    logic cfg_changed;
    logic dsi3_mode;
    logic psi5_mode;
    logic dsi3_policy;
    logic readable;
    logic rd_take;
    logic timer_zero;
    logic tx_take;
    logic tx_report;
    logic rd_supply;
    logic [1:0] clean_reads;
    logic supply_clear;
    logic memtemp_clear;
    logic err_code_pending;
    logic [7:0] next_rd_data;

    // oscillator rate derived from the core clock, then the 10-bit prescaler
    assign osc_en = (osc_div == OSC_TERM);
    assign tick_en = osc_en && (prescaler == PRESCALE_TERM);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_div <= 2'h0;
        end else if (osc_en) begin
            osc_div <= 2'h0;
        end else begin
            osc_div <= osc_div + 2'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prescaler <= 10'h0;
        end else if (tick_en) begin
            prescaler <= 10'h0;
        end else if (osc_en) begin
            prescaler <= prescaler + 10'h1;
        end
    end

    // wraps through 8'hff back to zero by natural overflow
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_counter <= TICK_COUNTER_RESET;
        end else if (tick_en) begin
            tick_counter <= tick_counter + 8'h01;
        end
    end

    // mode decode
    assign dsi3_mode = (interface_type_select == TYPE_DSI3_A)
        || (interface_type_select == TYPE_DSI3_B);
    assign psi5_mode = (interface_type_select == TYPE_PSI5_A)
        || (interface_type_select == TYPE_PSI5_B);
    assign dsi3_policy = dsi3_mode && !power_fault_clear_policy;
    assign readable = dsi3_mode || (psi5_mode && psi5_diag_mode);
    assign rd_take = rd_strobe && readable;
    assign rd_supply = rd_take && (rd_addr == ADDR_SUPPLY_FAULT_STATUS);

    // summaries
    assign dsp_fault = pressure_over_range | pressure_under_range | selftest_incomplete
        | common_mode_fault | selftest_fault;
    assign link_fault_status = {7'h00, oscillator_training_fault};
    assign link_fault_summary = |link_fault_status;
    assign memory_temperature_summary = |memory_temp_status;
    assign supply_summary = |supply_fault_status;
    assign top_device_status = {dsp_fault, 1'b0, link_fault_summary,
        memory_temperature_summary, supply_summary, factory_test_active,
        reset_occurred, initialising};

    // supply recovery timer, stepped at a parameter multiple of the tick
    assign supply_live = supply_monitor & SUPPLY_USED_MASK;
    assign supply_live_any = |supply_live;
    assign timer_zero = (recovery_timer == TIMER_ZERO);
    assign timer_step = tick_en && (rate_div == RATE_TERM);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_div <= 8'h00;
        end else if (timer_step || supply_live_any) begin
            rate_div <= 8'h00;
        end else if (tick_en) begin
            rate_div <= rate_div + 8'h01;
        end
    end

    // starts loaded: the monitors are not trusted until a full recovery has run
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            recovery_timer <= TIMER_RELOAD;
        end else if (supply_live_any) begin
            recovery_timer <= TIMER_RELOAD;
        end else if (timer_step && !timer_zero) begin
            recovery_timer <= recovery_timer - {{(TIMER_W-1){1'b0}}, 1'b1};
        end
    end

    // transmissions are held off while the timer runs, in every policy
    assign tx_permit = timer_zero;
    assign tx_take = tx_slot && tx_permit;
    assign tx_report = tx_take && tx_status_included;
    assign tx_send_error_code = dsi3_policy && err_code_pending && timer_zero;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_code_pending <= 1'b0;
        end else if (supply_live_any) begin
            err_code_pending <= 1'b1;
        end else if (!dsi3_policy || tx_take) begin
            err_code_pending <= 1'b0;
        end
    end

    // second clean read in a row empties the register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clean_reads <= 2'h0;
        end else if (supply_live_any) begin
            clean_reads <= 2'h0;
        end else if (rd_supply) begin
            clean_reads <= (clean_reads == 2'h0) ? 2'h1 : 2'h0;
        end
    end

    assign supply_clear = (dsi3_policy && timer_zero && (rd_supply || tx_report))
        || (!dsi3_policy && timer_zero)
        || (rd_supply && !supply_live_any && clean_reads == 2'h1);

    // live monitors are ored in every cycle, so a set always beats a clear and
    // bits reset to zero show the monitors from the first edge on
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            supply_fault_status <= 8'h00;
        end else if (supply_clear) begin
            supply_fault_status <= supply_live;
        end else begin
            supply_fault_status <= supply_fault_status | supply_live;
        end
    end

    // memory and temperature bits; the write-active bit is live only
    assign memtemp_live = {factory_otp_fault, user_otp_fault, user_rw_fault,
        user_otp_writing, 1'b0, temperature_fault, 2'b00};
    assign memtemp_clear = (rd_take && rd_addr == ADDR_MEMORY_TEMP_STATUS) || tx_report;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            memory_temp_status <= 8'h00;
        end else begin
            memory_temp_status[MT_WRITE_ACTIVE_BIT] <= user_otp_writing;
            for (int b = 0; b < 8; b++) begin
                if (b != MT_WRITE_ACTIVE_BIT && MEMTEMP_USED_MASK[b]) begin
                    memory_temp_status[b] <= memtemp_live[b]
                        | (memory_temp_status[b] & !memtemp_clear);
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_occurred <= 1'b1;
        end else if ((rd_take && rd_addr == ADDR_TOP_DEVICE_STATUS) || tx_report) begin
            reset_occurred <= 1'b0;
        end
    end

    // configuration change detect: a change wins over data-valid
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_prev <= 4'h0;
        end else begin
            cfg_prev <= channel_config_upper;
        end
    end

    assign cfg_changed = (cfg_prev != channel_config_upper);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            initialising <= 1'b1;
        end else if (cfg_changed) begin
            initialising <= 1'b1;
        end else if (sensor_data_valid) begin
            initialising <= 1'b0;
        end
    end

    // read mux; unmapped addresses and refused reads answer zero
    always_comb begin
        next_rd_data = READ_ZERO;
        if (!readable) begin
            next_rd_data = READ_ZERO;
        end else if (rd_addr == ADDR_TICK_COUNTER) begin
            next_rd_data = tick_counter;
        end else if (rd_addr == ADDR_TOP_DEVICE_STATUS) begin
            next_rd_data = top_device_status;
        end else if (rd_addr == ADDR_SUPPLY_FAULT_STATUS) begin
            next_rd_data = supply_fault_status;
        end else if (rd_addr == ADDR_MEMORY_TEMP_STATUS) begin
            next_rd_data = memory_temp_status;
        end else if (rd_addr == ADDR_LINK_FAULT_STATUS) begin
            next_rd_data = link_fault_status;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= READ_ZERO;
            rd_ack <= 1'b0;
            rd_refused <= 1'b0;
        end else begin
            rd_ack <= rd_take;
            rd_refused <= rd_strobe && !readable;
            if (rd_strobe) begin
                rd_data <= next_rd_data;
            end
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    a_tick_wraps: assert property (tick_en |=> tick_counter == $past(tick_counter) + 8'h01)
        else $error("tick counter did not advance by one");
    a_tick_spacing: assert property (tick_en |=> !tick_en [*8])
        else $error("tick enables too close");
    a_prescale_term: assert property (tick_en |-> prescaler == PRESCALE_TERM && osc_en)
        else $error("tick without prescaler terminal count");
    a_read_gated: assert property (rd_strobe && !readable
        |=> rd_refused && !rd_ack && rd_data == READ_ZERO)
        else $error("read answered outside allowed modes");
    a_status_read: assert property (rd_take && rd_addr == ADDR_TOP_DEVICE_STATUS
        |=> rd_ack && rd_data[TOP_DSP_BIT] == $past(dsp_fault)
        && rd_data[TOP_SUPPLY_BIT] == $past(|supply_fault_status))
        else $error("top status read wrong");
    a_dsp_summary: assert property (pressure_over_range && rd_take
        && rd_addr == ADDR_TOP_DEVICE_STATUS |=> rd_data[TOP_DSP_BIT])
        else $error("dsp fault missing");
    a_link_summary: assert property (oscillator_training_fault |-> top_device_status[TOP_LINK_BIT])
        else $error("link summary missing");
    a_memtemp_summary: assert property (temperature_fault |=> memory_temperature_summary)
        else $error("memory temperature summary missing");
    a_supply_summary: assert property (supply_monitor[SUP_BUF_LOW_BIT]
        |=> supply_summary && supply_fault_status[SUP_BUF_LOW_BIT])
        else $error("supply summary missing");
    a_timer_reload: assert property (supply_live_any |=> recovery_timer == TIMER_RELOAD)
        else $error("recovery timer not reloaded");
    // a slot offered while recovering must not consume the pending error code
    a_tx_silence: assert property (!timer_zero && tx_slot && dsi3_policy && !supply_live_any
        |=> !$past(tx_permit) && err_code_pending == $past(err_code_pending))
        else $error("transmission while recovering");
    a_code_once: assert property (tx_take && tx_send_error_code && !supply_live_any
        |=> !tx_send_error_code)
        else $error("error code sent more than once");
    // the second clean read may empty the register early, so it is left out here
    a_dsi_hold: assert property (dsi3_policy && !timer_zero && !supply_live_any
        && !(rd_supply && clean_reads == 2'h1)
        && supply_fault_status[SUP_BUS_LOW_BIT] |=> supply_fault_status[SUP_BUS_LOW_BIT])
        else $error("supply error cleared before timer expiry");
    a_psi_clear: assert property (!dsi3_policy && timer_zero && !supply_live_any
        |=> supply_fault_status == 8'h00)
        else $error("supply error not cleared at timer zero");
    a_reset_clear: assert property (rd_take && rd_addr == ADDR_TOP_DEVICE_STATUS
        |=> !reset_occurred)
        else $error("reset flag not cleared by read");
    a_init_set: assert property (cfg_changed |=> initialising)
        else $error("initialising not set on config change");
    a_otp_live: assert property (1'b1 |=> memory_temp_status[MT_WRITE_ACTIVE_BIT]
        == $past(user_otp_writing))
        else $error("write active bit not live");
    a_memtemp_clear: assert property (rd_take && rd_addr == ADDR_MEMORY_TEMP_STATUS
        && !temperature_fault |=> !memory_temp_status[2])
        else $error("temperature fault not cleared by read");
endmodule : sst_status_regs

// >>> tb/sst_link_master.sv
// bus master model that offers response slots to the sensor and logs what it got
module sst_link_master (
    // clock
    input wire logic core_clk,
    // commands from the bench
    input wire logic fire,
    input wire logic with_status,
    // sensor side
    input wire logic tx_permit,
    input wire logic tx_send_error_code,
    output logic tx_slot,
    output logic tx_status_included,
    // observation
    output logic [7:0] taken,
    output logic last_err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic go = 1'b0;
    logic go_st = 1'b0;
    initial begin
        tx_slot = 1'b0;
        tx_status_included = 1'b0;
        taken = 8'h00;
        last_err = 1'b0;
    end
    // commands are latched on the rising edge so the bench never races the slot driver
    always @(posedge core_clk) begin
        go <= fire;
        go_st <= with_status;
        if (tx_slot && tx_permit) begin
            taken <= taken + 8'h01;
            last_err <= tx_send_error_code;
        end
    end
    // the status qualifier means nothing outside a slot, so it is dropped there
    always @(negedge core_clk) begin
        tx_slot <= go;
        tx_status_included <= go & go_st;
    end
endmodule : sst_link_master

// >>> tb/sensor_status_and_tick_registers_tb.sv
// self-checking bench for the sensor status and tick registers
module sensor_status_and_tick_registers_tb;
    import sst_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RCV = 2;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] itype = TYPE_DSI3_A;
    logic diag = 1'b0;
    logic policy = 1'b0;
    logic rd_strobe = 1'b0;
    logic [7:0] rd_addr = 8'h00;
    logic [7:0] rd_data;
    logic rd_ack;
    logic rd_refused;
    logic tx_slot;
    logic tx_status_included;
    logic tx_permit;
    logic tx_send_error_code;
    logic [4:0] dsp = 5'h00;
    logic [7:0] supply_monitor = 8'h00;
    logic [4:0] mt = 5'h00;
    logic osc_fault = 1'b0;
    logic test_mode = 1'b0;
    logic [3:0] cfg = 4'h0;
    logic data_valid = 1'b0;
    logic [7:0] recovery_timer;
    logic [7:0] tick_counter;
    logic fire = 1'b0;
    logic with_status = 1'b0;
    logic [7:0] taken;
    logic last_err;
    logic want_ack = 1'b1;
    logic [7:0] rv;
    logic [7:0] e;
    logic [7:0] t0;
    int errors = 0;
    int compares = 0;

    always #12.5 core_clk = ~core_clk;

    sst_status_regs #(.TIMER_W(8), .RECOVERY_TICKS(RCV), .TIMER_RATE_TICKS(1)) u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .interface_type_select(itype),
        .psi5_diag_mode(diag), .power_fault_clear_policy(policy),
        .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data), .rd_ack(rd_ack),
        .rd_refused(rd_refused), .tx_slot(tx_slot), .tx_status_included(tx_status_included),
        .tx_permit(tx_permit), .tx_send_error_code(tx_send_error_code),
        .pressure_over_range(dsp[4]), .pressure_under_range(dsp[3]),
        .selftest_incomplete(dsp[2]), .common_mode_fault(dsp[1]), .selftest_fault(dsp[0]),
        .supply_monitor(supply_monitor), .factory_otp_fault(mt[4]), .user_otp_fault(mt[3]),
        .user_rw_fault(mt[2]), .user_otp_writing(mt[1]), .temperature_fault(mt[0]),
        .oscillator_training_fault(osc_fault), .factory_test_active(test_mode),
        .channel_config_upper(cfg), .sensor_data_valid(data_valid),
        .recovery_timer(recovery_timer), .tick_counter(tick_counter));

    sst_link_master u_master (
        .core_clk(core_clk), .fire(fire), .with_status(with_status), .tx_permit(tx_permit),
        .tx_send_error_code(tx_send_error_code), .tx_slot(tx_slot),
        .tx_status_included(tx_status_included), .taken(taken), .last_err(last_err));

    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
        compares++;
        if (g !== ex) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, ex, g);
        end
    endtask : chk

    // one-cycle strobe, answer looked at in the cycle it stands
    task automatic rdc(input logic [7:0] a, input logic [7:0] ex, input logic [7:0] m);
        @(negedge core_clk);
        rd_strobe = 1'b1;
        rd_addr = a;
        @(negedge core_clk);
        rd_strobe = 1'b0;
        rv = rd_data;
        chk("rd_answer", {6'h00, want_ack, ~want_ack}, {6'h00, rd_ack, rd_refused});
        chk("rd_data", ex, rv & m);
    endtask : rdc

    task automatic fault(input logic [7:0] v);
        @(negedge core_clk);
        supply_monitor = v;
        repeat (2) @(negedge core_clk);
        chk("recovery_timer", 8'(RCV), recovery_timer);
        chk("tx_permit", 8'h00, {7'h00, tx_permit});
        supply_monitor = 8'h00;
    endtask : fault

    task automatic slot(input logic st);
        @(negedge core_clk);
        fire = 1'b1;
        with_status = st;
        @(negedge core_clk);
        fire = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask : slot

    // the wait is bounded by two tick periods plus margin
    task automatic wait_permit;
        int n;
        n = 0;
        while (tx_permit !== 1'b1 && n < 12000) begin
            @(negedge core_clk);
            n++;
        end
        chk("tx_permit", 8'h01, {7'h00, tx_permit});
    endtask : wait_permit

    task automatic tally_and_finish;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (80000) @(posedge core_clk);
        errors++;
        tally_and_finish();
    end

    initial begin
        repeat (10) @(negedge core_clk);
        rst_n = 1'b1;
        chk("tx_permit", 8'h00, {7'h00, tx_permit});
        chk("tick_counter", TICK_COUNTER_RESET, tick_counter);
        rdc(ADDR_TICK_COUNTER, 8'h00, 8'hFF);
        rdc(ADDR_TOP_DEVICE_STATUS, 8'h03, 8'hFF);
        rdc(ADDR_TOP_DEVICE_STATUS, 8'h01, 8'hFF);
        data_valid = 1'b1;
        @(negedge core_clk);
        data_valid = 1'b0;
        rdc(ADDR_TOP_DEVICE_STATUS, 8'h00, 8'hFF);
        cfg = 4'h5;
        rdc(ADDR_TOP_DEVICE_STATUS, 8'h01, 8'h01);
        test_mode = 1'b1;
        rdc(ADDR_TOP_DEVICE_STATUS, 8'h04, 8'h04);
        test_mode = 1'b0;
        // strobes exactly one tick period apart see exactly one advance
        rdc(ADDR_TICK_COUNTER, 8'h00, 8'h00);
        t0 = rv;
        repeat (3998) @(negedge core_clk);
        rdc(ADDR_TICK_COUNTER, t0 + 8'h01, 8'hFF);
        for (int i = 0; i < 5; i++) begin
            dsp = 5'(1 << i);
            rdc(ADDR_TOP_DEVICE_STATUS, 8'h80, 8'h80);
            dsp = 5'h00;
            rdc(ADDR_TOP_DEVICE_STATUS, 8'h00, 8'h80);
        end
        osc_fault = 1'b1;
        rdc(ADDR_TOP_DEVICE_STATUS, 8'h20, 8'h20);
        rdc(ADDR_LINK_FAULT_STATUS, 8'h01, 8'hFF);
        osc_fault = 1'b0;
        rdc(ADDR_LINK_FAULT_STATUS, 8'h00, 8'hFF);
        for (int i = 0; i < 5; i++) begin
            mt = 5'(1 << i);
            e = {mt[4:1], 1'b0, mt[0], 2'b00};
            rdc(ADDR_TOP_DEVICE_STATUS, 8'h10, 8'h10);
            rdc(ADDR_MEMORY_TEMP_STATUS, e, 8'hFF);
            mt = 5'h00;
            rdc(ADDR_MEMORY_TEMP_STATUS, (i == 1) ? 8'h00 : e, 8'hFF);
            rdc(ADDR_MEMORY_TEMP_STATUS, 8'h00, 8'hFF);
        end
        for (int k = 0; k < 2; k++) begin
            itype = (k == 0) ? TYPE_PSI5_A : TYPE_PSI5_B;
            diag = 1'b0;
            want_ack = 1'b0;
            rdc(ADDR_TICK_COUNTER, 8'h00, 8'hFF);
            rdc(ADDR_TOP_DEVICE_STATUS, 8'h00, 8'hFF);
            want_ack = 1'b1;
            diag = 1'b1;
            rdc(ADDR_LINK_FAULT_STATUS, 8'h00, 8'hFF);
        end
        itype = TYPE_DSI3_B;
        diag = 1'b0;
        rdc(ADDR_LINK_FAULT_STATUS, 8'h00, 8'hFF);
        rdc(8'h05, 8'h00, 8'hFF);
        itype = TYPE_DSI3_A;
        wait_permit();
        slot(1'b1);
        for (int i = 0; i < 8; i++) begin
            if (SUPPLY_USED_MASK[i]) begin
                fault(8'(1 << i));
                rdc(ADDR_TOP_DEVICE_STATUS, 8'h08, 8'h08);
                rdc(ADDR_SUPPLY_FAULT_STATUS, 8'(1 << i), 8'hFF);
                rdc(ADDR_SUPPLY_FAULT_STATUS, 8'h00, 8'h00);
                rdc(ADDR_SUPPLY_FAULT_STATUS, 8'h00, 8'hFF);
            end
        end
        fault(8'h80);
        t0 = taken;
        slot(1'b1);
        chk("taken", t0, taken);
        rdc(ADDR_SUPPLY_FAULT_STATUS, 8'h80, 8'hFF);
        wait_permit();
        chk("error_code", 8'h01, {7'h00, tx_send_error_code});
        slot(1'b0);
        chk("error_code", 8'h00, {7'h00, tx_send_error_code});
        chk("last_err", 8'h01, {7'h00, last_err});
        rdc(ADDR_SUPPLY_FAULT_STATUS, 8'h80, 8'hFF);
        rdc(ADDR_SUPPLY_FAULT_STATUS, 8'h00, 8'hFF);
        fault(8'h40);
        wait_permit();
        slot(1'b1);
        rdc(ADDR_SUPPLY_FAULT_STATUS, 8'h00, 8'hFF);
        policy = 1'b1;
        fault(8'h20);
        wait_permit();
        chk("error_code", 8'h00, {7'h00, tx_send_error_code});
        rdc(ADDR_SUPPLY_FAULT_STATUS, 8'h00, 8'hFF);
        policy = 1'b0;
        itype = TYPE_PSI5_B;
        diag = 1'b1;
        fault(8'h01);
        wait_permit();
        chk("error_code", 8'h00, {7'h00, tx_send_error_code});
        rdc(ADDR_SUPPLY_FAULT_STATUS, 8'h00, 8'hFF);
        tally_and_finish();
    end
endmodule : sensor_status_and_tick_registers_tb
